// File: sim/eps_mem_model.sv
/* eps_mem_model: byte-wide program memory, one read in flight.
   assumes single-cycle strobes with the address beside them. */
`timescale 1ns/1ps
module eps_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        slow_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic             rvalid_o,
  output logic [7:0]       rdata_o
);
  logic [7:0]  mem [0:65535]; // whole space, so wrap lands in it
  logic [15:0] ra;            // address in flight
  logic [2:0]  rq;            // strobe history
  wire  logic  hit = slow_i ? rq[2] : rq[0]; // slow is two cycles later
  // idle data flips so a stale byte never passes as valid
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {rvalid_o, rdata_o, rq, ra} <= '0;
    end else begin
      rq       <= {rq[1:0], re_i};
      rvalid_o <= hit;
      rdata_o  <= hit ? mem[ra] : ~rdata_o;
      if (re_i) ra <= addr_i;
      if (we_i) mem[addr_i] <= wdata_i;
    end
  end
endmodule

// File: sim/eps_seq_props.sv
/* eps_seq_props: checks memory traffic, modes and pointer steps of eps_sequencer.
   assumes it is bound to every eps_sequencer instance. */
`timescale 1ns/1ps
module eps_seq_props (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_we_o,
  input wire logic        mem_re_o,
  input wire logic        mem_rvalid_i,
  input wire logic        running_o,
  input wire logic        storing_o,
  input wire logic [15:0] ptr_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // earliest next fetch is three cycles on
  sequence s_no_read2; !mem_re_o [*2]; endsequence
  a_we_entry: assert property (mem_we_o |-> storing_o) else $error("stray write");
  a_we_step: assert property (mem_we_o |-> ptr_o == 16'(mem_addr_o + 16'h0001)) else $error("bad step");
  a_entry_quiet: assert property (storing_o |-> !mem_re_o) else $error("read in entry");
  a_modes_apart: assert property (!(running_o && storing_o)) else $error("two modes");
  a_keep_ptr: assert property ($fell(storing_o) |-> $stable(ptr_o)) else $error("stop moved ptr");
  a_re_at_ptr: assert property (mem_re_o |-> running_o && mem_addr_o == ptr_o) else $error("bad fetch");
  a_one_read: assert property (mem_re_o |=> s_no_read2) else $error("reads too close");
  a_rd_step: assert property (mem_rvalid_i && running_o |=> ptr_o == 16'($past(ptr_o) + 16'h0001))
    else $error("bad fetch step");
endmodule
bind eps_sequencer eps_seq_props u_props (.*);

// File: sim/tb.sv
/* tb: ascii and binary commands into eps_sequencer, eps_mem_model as memory.
   assumes handed-off commands are answered one cycle after their pulse. */
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, nrst = 1'b0, hv = 1'b0, slow = 1'b0, asc = 1'b1, xd = 1'b0;
  logic [7:0]  hc = 8'h00, wd, rd, xop;
  logic [15:0] addr, ptr, xa0, xa1, tbits = 16'h0000;
  logic        rdy, we, re, rv, run, sto, ev;
  int          fail_count = 0, total_checks = 0, skipped = 0; // reads of jumped byte
  int          xcnt = 0; // handed-off commands seen
  eps_sequencer uut (.mclk_i(clk), .nrst_i(nrst), .ascii_format_bit_i(asc), .host_valid_i(hv),
    .host_char_i(hc), .host_ready_o(rdy), .mem_addr_o(addr), .mem_wdata_o(wd), .mem_we_o(we),
    .mem_re_o(re), .mem_rvalid_i(rv), .mem_rdata_i(rd), .test_bits_i(tbits), .exec_valid_o(ev),
    .exec_op_o(xop), .exec_arg0_o(xa0), .exec_arg1_o(xa1), .exec_done_i(xd), .running_o(run),
    .storing_o(sto), .ptr_o(ptr));
  eps_mem_model pm (.mclk_i(clk), .nrst_i(nrst), .slow_i(slow), .we_i(we), .re_i(re),
    .addr_i(addr), .wdata_i(wd), .rvalid_o(rv), .rdata_o(rd));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (re && addr == 16'h0002) skipped++;
  // the other block finishes each handed-off command one cycle after its pulse
  always @(posedge clk) begin
    xd <= ev;
    if (ev) xcnt++;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // held until taken, idle cycle after each, then room to finish
  task put(input logic [7:0] c);
    hv <= 1'b1;
    hc <= c;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hv <= 1'b0;
    @(posedge clk);
  endtask
  task send(input string s);
    foreach (s[i]) put(s[i]);
    repeat (20) @(posedge clk);
  endtask
  // binary bytes, first byte in the top used slot
  task sendb(input logic [127:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) put(v[i*8 +: 8]);
    repeat (20) @(posedge clk);
  endtask
  // bounded wait for a program to end
  task idle;
    repeat (1000) if (run === 1'b1) @(posedge clk);
  endtask
  // pointer load, then a program stored across the top of memory
  task t_store;
    send("Y5\r");
    chk(ptr, 16'h0005);
    send("Y65535\rE\r");
    chk(sto, 1'b1);
    send("J4\r0\r0\rQ");
    chk(sto, 1'b0);
    chk(ptr, 16'h0006);
    chk(pm.mem[16'hffff], 8'h4a);
    // an endless loop at 6 with no repeat inside it
    send("E\rY6\rQ");
  endtask
  // slow run of the wrapped program, then a host halt of the endless one
  task t_run;
    slow <= 1'b1;
    send("Y65535\rX\r");
    idle();
    chk(run, 1'b0);
    chk(16'(skipped), 16'h0000);
    slow <= 1'b0;
    send("Y6\rX\r");
    chk(run, 1'b1);
    send("0\r");
    chk(run, 1'b0);
  endtask
  // byte loop nested in a wide loop, then a bit test that skips or not
  task t_branch;
    send("Y32\rE\rN1\rL2,32\rZ1,32\rT16,57\rN2\r0\rQ");
    send("Y32\rX\r");
    idle();
    chk(16'(xcnt), 16'h0006);
    chk(xa0, 16'h0001);
    tbits <= 16'h0001;
    send("Y32\rX\r");
    idle();
    chk(16'(xcnt), 16'h000d);
    chk(xa0, 16'h0002);
    chk(xop, 8'h4e);
  endtask
  // binary format: pointer, store, stop without count, run, zero halt
  task t_binary;
    asc <= 1'b0;
    sendb(128'h59020040_45004e02_07090000_51, 13);
    chk(sto, 1'b0);
    chk(ptr, 16'h0046);
    sendb(128'h5902004058_00, 6);
    idle();
    chk(run, 1'b0);
    chk(xa0, 16'h0007);
    chk(xa1, 16'h0009);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_store();
    t_run();
    t_branch();
    t_binary();
    summarize();
  end
  // tests need under 2000 cycles; this 20000-cycle limit is ten times that
  initial begin
    #100us;
    fail_count++;
    summarize();
  end
endmodule

// File: verilog/eps_cmd_asm.sv
/*
  eps_cmd_asm: assembles a stream of command characters into one command:
  opcode plus two argument fields, in ASCII or binary format.
  Assumes one character per valid cycle and at least one idle cycle
  between a command's last character and the next command's first.
*/
`timescale 1ns/1ps
module eps_cmd_asm (
  input  wire logic        mclk_i,   // system clock
  input  wire logic        nrst_i,   // async reset, active low
  input  wire logic        clr_i,    // drop any partial command
  input  wire logic        valid_i,  // character strobe
  input  wire logic [7:0]  char_i,   // character
  input  wire logic        ascii_i,  // format select
  output logic             idle_o,   // waiting for an opcode
  output logic             done_o,   // one-cycle command complete
  output logic [7:0]       op_o,     // opcode
  output logic [15:0]      f0_o,     // first argument
  output logic [15:0]      f1_o      // second argument
);

  eps_pkg::eps_parse_t st, next_st; // assembler state
  logic        fsel, next_fsel; // ASCII field index
  logic [7:0]  cnt, next_cnt;   // binary bytes still due
  logic [7:0]  tot, next_tot;   // binary total count
  logic [23:0] acc, next_acc;   // binary byte shifter
  logic        next_done;
  logic [7:0]  next_op;
  logic [15:0] next_f0;
  logic [15:0] next_f1;

  // decimal digit accumulate, ten times plus the digit
  function automatic logic [15:0] dec_step(input logic [15:0] f, input logic [7:0] c);
    logic [15:0] d;
    d = {8'h00, c - eps_pkg::CH_DIGIT0};
    dec_step = (f << 3) + (f << 1) + d;
  endfunction

  assign idle_o = (st == eps_pkg::PS_OP);

  // next-state and field assembly
  always_comb begin
    logic [23:0] sh;
    sh        = {acc[15:0], char_i};
    next_st   = st;
    next_fsel = fsel;
    next_cnt  = cnt;
    next_tot  = tot;
    next_acc  = acc;
    next_done = 1'b0;
    next_op   = op_o;
    next_f0   = f0_o;
    next_f1   = f1_o;
    if (clr_i) begin
      next_st = eps_pkg::PS_OP;
    end else if (valid_i) begin
      unique case (st)
        eps_pkg::PS_OP: begin
          // stop_storing stands alone in both formats
          if (char_i == eps_pkg::OP_STOP_STORE) begin
            next_op   = char_i;
            next_f0   = 16'h0000;
            next_f1   = 16'h0000;
            next_done = 1'b1;
          end else if (!ascii_i) begin
            next_op = char_i;
            next_st = eps_pkg::PS_CNT;
          end else if (char_i != eps_pkg::CH_CR && char_i != eps_pkg::CH_SPACE) begin
            next_op   = char_i;
            next_f0   = 16'h0000;
            next_f1   = 16'h0000;
            next_fsel = 1'b0;
            next_st   = eps_pkg::PS_ARGS;
          end
        end
        eps_pkg::PS_ARGS: begin
          // decimal digits, comma moves to second field, cr ends
          if (char_i == eps_pkg::CH_CR) begin
            next_done = 1'b1;
            next_st   = eps_pkg::PS_OP;
          end else if (char_i == eps_pkg::CH_COMMA) begin
            next_fsel = 1'b1;
          end else if (char_i >= eps_pkg::CH_DIGIT0 && char_i <= eps_pkg::CH_DIGIT9) begin
            if (fsel) begin
              next_f1 = dec_step(f1_o, char_i);
            end else begin
              next_f0 = dec_step(f0_o, char_i);
            end
          end
        end
        eps_pkg::PS_CNT: begin
          // zero count completes at once, as binary halt_run does
          next_cnt = char_i;
          next_tot = char_i;
          next_acc = 24'h000000;
          next_f0  = 16'h0000;
          next_f1  = 16'h0000;
          if (char_i == 8'h00) begin
            next_done = 1'b1;
            next_st   = eps_pkg::PS_OP;
          end else begin
            next_st = eps_pkg::PS_DATA;
          end
        end
        eps_pkg::PS_DATA: begin
          // big-endian bytes; split once the last has arrived
          next_acc = sh;
          next_cnt = cnt - 8'h01;
          if (cnt == 8'h01) begin
            next_done = 1'b1;
            next_st   = eps_pkg::PS_OP;
            if (tot == eps_pkg::BIN_CNT_ONE) begin
              next_f0 = {8'h00, sh[7:0]};
            end else if (tot == eps_pkg::BIN_CNT_TWO && op_o == eps_pkg::OP_SET_PTR) begin
              next_f0 = sh[15:0];
            end else if (tot == eps_pkg::BIN_CNT_TWO) begin
              next_f0 = {8'h00, sh[15:8]};
              next_f1 = {8'h00, sh[7:0]};
            end else begin
              next_f0 = sh[23:8];
              next_f1 = {8'h00, sh[7:0]};
            end
          end
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st     <= eps_pkg::PS_OP;
      fsel   <= 1'b0;
      cnt    <= 8'h00;
      tot    <= 8'h00;
      acc    <= 24'h000000;
      done_o <= 1'b0;
      op_o   <= 8'h00;
      f0_o   <= 16'h0000;
      f1_o   <= 16'h0000;
    end else begin
      st     <= next_st;
      fsel   <= next_fsel;
      cnt    <= next_cnt;
      tot    <= next_tot;
      acc    <= next_acc;
      done_o <= next_done;
      op_o   <= next_op;
      f0_o   <= next_f0;
      f1_o   <= next_f1;
    end
  end

endmodule

// File: verilog/eps_constfix.sv
`timescale 1ns/1ps

// File: verilog/eps_pkg.sv
/*
  eps_pkg: constants and types shared by the external program sequencer.
  Holds the command character codes, the parser field layout, the bit-test
  field positions, reset values and the two state encodings.
  Assumes the host and the external memory both carry 8-bit characters.
*/
package eps_pkg;

  // command opcodes, the same byte in both formats except halt_run
  localparam logic [7:0] OP_SET_PTR     = 8'h59; // set pointer / long jump
  localparam logic [7:0] OP_START_STORE = 8'h45; // enter program entry
  localparam logic [7:0] OP_STOP_STORE  = 8'h51; // leave program entry
  localparam logic [7:0] OP_RUN         = 8'h58; // start execution
  localparam logic [7:0] OP_SHORT_BR    = 8'h4a; // in-page jump
  localparam logic [7:0] OP_BYTE_REP    = 8'h4c; // byte-count repeat
  localparam logic [7:0] OP_WIDE_REP    = 8'h5a; // wide-count repeat
  localparam logic [7:0] OP_MISMATCH_BR = 8'h54; // branch while inputs differ
  localparam logic [7:0] OP_HALT_ASCII  = 8'h30; // halt_run, ASCII format
  localparam logic [7:0] OP_HALT_BIN    = 8'h00; // halt_run, binary format

  // ASCII framing characters
  localparam logic [7:0] CH_CR     = 8'h0d; // command terminator
  localparam logic [7:0] CH_COMMA  = 8'h2c; // argument separator
  localparam logic [7:0] CH_SPACE  = 8'h20; // ignored filler
  localparam logic [7:0] CH_DIGIT0 = 8'h30; // lowest decimal digit
  localparam logic [7:0] CH_DIGIT9 = 8'h39; // highest decimal digit

  // binary data counts that select how the argument bytes split
  localparam logic [7:0] BIN_CNT_ONE   = 8'h01; // single byte argument
  localparam logic [7:0] BIN_CNT_TWO   = 8'h02; // two bytes
  localparam logic [7:0] BIN_CNT_THREE = 8'h03; // wide count plus target

  // bit-test parameter fields of branch_on_mismatch
  localparam int TEST_GROUP_POS = 6; // set: compare the six-bit group
  localparam int TEST_LEVEL_POS = 4; // expected level for one bit
  localparam int TEST_SEL_W     = 4; // width of single-bit selector
  localparam int TEST_GROUP_W   = 6; // width of the group compare

  // reset value and pointer increment
  localparam logic [15:0] PTR_RST = 16'h0000; // pointer after reset
  localparam logic [15:0] ONE16   = 16'h0001; // pointer increment

  // sequencer states, gray along direct-fetch-read-parse
  typedef enum logic [2:0] {
    ST_DIRECT  = 3'b000,
    ST_FETCH   = 3'b001,
    ST_WAIT_RD = 3'b011,
    ST_PARSE   = 3'b010,
    ST_EXEC    = 3'b110,
    ST_ENTRY   = 3'b100
  } eps_state_t;

  // character assembler states
  typedef enum logic [1:0] {
    PS_OP   = 2'b00,
    PS_ARGS = 2'b01,
    PS_CNT  = 2'b11,
    PS_DATA = 2'b10
  } eps_parse_t;

endpackage

// File: verilog/eps_sequencer.sv
/*
  eps_sequencer: external program sequencer. Records host commands into a
  byte-wide external memory, runs programs from it, handles jumps, the two
  repeat counters and interleaved host commands. Commands it does not own
  go out on the exec port and are waited for.
  Assumes host characters, memory read data, exec_done_i, test bits and
  the format bit all come from logic on mclk_i; memory writes take one
  cycle and a read answers with mem_rvalid_i one or more cycles later.
*/
`timescale 1ns/1ps
module eps_sequencer (
  input  wire logic        mclk_i,             // 200 MHz system clock
  input  wire logic        nrst_i,             // async reset, active low
  input  wire logic        ascii_format_bit_i, // mode register top bit
  input  wire logic        host_valid_i,       // host character offered
  input  wire logic [7:0]  host_char_i,        // host character
  output logic             host_ready_o,       // character taken when high
  output logic [15:0]      mem_addr_o,         // memory address
  output logic [7:0]       mem_wdata_o,        // memory write data
  output logic             mem_we_o,           // one-cycle write strobe
  output logic             mem_re_o,           // one-cycle read strobe
  input  wire logic        mem_rvalid_i,       // read data valid
  input  wire logic [7:0]  mem_rdata_i,        // read data
  input  wire logic [15:0] test_bits_i,        // signals for bit test
  output logic             exec_valid_o,       // one-cycle command out
  output logic [7:0]       exec_op_o,          // its opcode
  output logic [15:0]      exec_arg0_o,        // its first argument
  output logic [15:0]      exec_arg1_o,        // its second argument
  input  wire logic        exec_done_i,        // other block finished
  output logic             running_o,          // execution mode
  output logic             storing_o,          // entry mode
  output logic [15:0]      ptr_o               // address pointer
);

  eps_pkg::eps_state_t state, next_state; // sequencer state
  logic        in_run, next_in_run; // program execution mode
  logic [15:0] ptr, next_ptr;       // memory address pointer
  logic        hp_valid, next_hp_valid; // host command waiting
  logic [7:0]  hp_op, next_hp_op;
  logic [15:0] hp_f0, next_hp_f0;
  logic [15:0] hp_f1, next_hp_f1;
  logic [7:0]  lp_cnt, next_lp_cnt;   // byte repeat counter
  logic        lp_act, next_lp_act;   // byte repeat active
  logic [15:0] zl_cnt, next_zl_cnt;   // wide repeat counter
  logic        zl_act, next_zl_act;   // wide repeat active
  logic        next_host_ready;
  logic [15:0] next_mem_addr;
  logic [7:0]  next_mem_wdata;
  logic        next_mem_we;
  logic        next_mem_re;
  logic        next_exec_valid;
  logic [7:0]  next_exec_op;
  logic [15:0] next_exec_arg0;
  logic [15:0] next_exec_arg1;
  logic        h_take;     // host character taken this cycle
  logic        h_idle;     // host assembler between commands
  logic        h_done;     // host command complete
  logic [7:0]  h_op;
  logic [15:0] h_f0;
  logic [15:0] h_f1;
  logic        m_feed;     // fetched character to assembler
  logic        m_clr;      // drop partial fetched command
  logic        m_done;     // fetched command complete
  logic [7:0]  m_op;
  logic [15:0] m_f0;
  logic [15:0] m_f1;
  logic        go;         // a whole command is to be acted on
  logic [7:0]  c_op;
  logic [15:0] c_f0;
  logic [15:0] c_f1;
  logic [7:0]  halt_op;    // halt_run for the current format

  assign ptr_o  = ptr;
  assign h_take = host_valid_i & host_ready_o;
  assign m_feed = (state == eps_pkg::ST_WAIT_RD) & mem_rvalid_i;
  // the format bit picks which byte means halt_run
  assign halt_op = ascii_format_bit_i ? eps_pkg::OP_HALT_ASCII : eps_pkg::OP_HALT_BIN;

  // true when the selected test inputs differ from the parameter
  function automatic logic bit_mismatch(input logic [7:0] prm, input logic [15:0] bits);
    logic [eps_pkg::TEST_SEL_W-1:0] sel;
    sel = prm[eps_pkg::TEST_SEL_W-1:0];
    if (prm[eps_pkg::TEST_GROUP_POS]) begin
      bit_mismatch = bits[eps_pkg::TEST_GROUP_W-1:0] != prm[eps_pkg::TEST_GROUP_W-1:0];
    end else begin
      bit_mismatch = bits[sel] != prm[eps_pkg::TEST_LEVEL_POS];
    end
  endfunction

  // host characters: assembled while direct, running or storing
  eps_cmd_asm u_host_asm (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .clr_i   (1'b0),
    .valid_i (h_take),
    .char_i  (host_char_i),
    .ascii_i (ascii_format_bit_i),
    .idle_o  (h_idle),
    .done_o  (h_done),
    .op_o    (h_op),
    .f0_o    (h_f0),
    .f1_o    (h_f1)
  );

  // fetched characters: a separate assembler so both streams interleave
  eps_cmd_asm u_mem_asm (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .clr_i   (m_clr),
    .valid_i (m_feed),
    .char_i  (mem_rdata_i),
    .ascii_i (ascii_format_bit_i),
    .idle_o  (),
    .done_o  (m_done),
    .op_o    (m_op),
    .f0_o    (m_f0),
    .f1_o    (m_f1)
  );

  // sequencer next values
  always_comb begin
    next_state      = state;
    next_in_run     = in_run;
    next_ptr        = ptr;
    next_hp_valid   = hp_valid;
    next_hp_op      = hp_op;
    next_hp_f0      = hp_f0;
    next_hp_f1      = hp_f1;
    next_lp_cnt     = lp_cnt;
    next_lp_act     = lp_act;
    next_zl_cnt     = zl_cnt;
    next_zl_act     = zl_act;
    next_mem_addr   = mem_addr_o;
    next_mem_wdata  = mem_wdata_o;
    next_mem_we     = 1'b0;
    next_mem_re     = 1'b0;
    next_exec_valid = 1'b0;
    next_exec_op    = exec_op_o;
    next_exec_arg0  = exec_arg0_o;
    next_exec_arg1  = exec_arg1_o;
    m_clr           = 1'b0;
    go              = 1'b0;
    c_op            = hp_op;
    c_f0            = hp_f0;
    c_f1            = hp_f1;

    // a finished host command waits here; storing records instead
    if (h_done && state != eps_pkg::ST_ENTRY) begin
      next_hp_valid = 1'b1;
      next_hp_op    = h_op;
      next_hp_f0    = h_f0;
      next_hp_f1    = h_f1;
    end

    unique case (state)
      eps_pkg::ST_DIRECT: begin
        if (hp_valid) begin
          go            = 1'b1;
          next_hp_valid = 1'b0;
        end
      end
      eps_pkg::ST_ENTRY: begin
        // stop_storing is spotted on its first character and not stored
        if (h_take && h_idle && host_char_i == eps_pkg::OP_STOP_STORE) begin
          next_state = eps_pkg::ST_DIRECT;
        end else if (h_take) begin
          next_mem_we    = 1'b1;
          next_mem_addr  = ptr;
          next_mem_wdata = host_char_i;
          next_ptr       = ptr + eps_pkg::ONE16;
        end
      end
      eps_pkg::ST_FETCH: begin
        // host commands slot in before each fetch, so also between characters of one fetched command
        if (hp_valid) begin
          go            = 1'b1;
          next_hp_valid = 1'b0;
        end else begin
          next_mem_re   = 1'b1;
          next_mem_addr = ptr;
          next_state    = eps_pkg::ST_WAIT_RD;
        end
      end
      eps_pkg::ST_WAIT_RD: begin
        // pointer moves on every read, so page crossings land early
        if (mem_rvalid_i) begin
          next_ptr   = ptr + eps_pkg::ONE16;
          next_state = eps_pkg::ST_PARSE;
        end
      end
      eps_pkg::ST_PARSE: begin
        if (m_done) begin
          go   = 1'b1;
          c_op = m_op;
          c_f0 = m_f0;
          c_f1 = m_f1;
        end else begin
          next_state = eps_pkg::ST_FETCH;
        end
      end
      eps_pkg::ST_EXEC: begin
        if (exec_done_i) begin
          next_state = in_run ? eps_pkg::ST_FETCH : eps_pkg::ST_DIRECT;
        end
      end
      default: begin
        next_state = eps_pkg::ST_DIRECT;
      end
    endcase

    // act on one whole command, host or fetched alike
    if (go) begin
      next_state = in_run ? eps_pkg::ST_FETCH : eps_pkg::ST_DIRECT;
      if (c_op == halt_op) begin
        next_in_run = 1'b0;
        next_state  = eps_pkg::ST_DIRECT;
        m_clr       = 1'b1;
      end else begin
        unique case (c_op)
          eps_pkg::OP_SET_PTR: begin
            // direct: pointer only; fetched: continues from it
            next_ptr = c_f0;
          end
          eps_pkg::OP_START_STORE: begin
            if (!in_run) begin
              next_state = eps_pkg::ST_ENTRY;
            end
          end
          eps_pkg::OP_RUN: begin
            if (!in_run) begin
              next_in_run = 1'b1;
              next_state  = eps_pkg::ST_FETCH;
              m_clr       = 1'b1;
            end
          end
          eps_pkg::OP_STOP_STORE: begin
            // outside entry it has nothing to stop
            next_state = next_state;
          end
          eps_pkg::OP_SHORT_BR: begin
            next_ptr = {ptr[15:8], c_f0[7:0]};
          end
          eps_pkg::OP_BYTE_REP: begin
            // one counter per kind; a same-kind inner loop would count down the outer's counter
            if (lp_act && lp_cnt == 8'h00) begin
              next_lp_act = 1'b0;
            end else if (!lp_act && c_f0[7:0] == 8'h00) begin
              next_lp_act = 1'b0;
            end else begin
              next_lp_act = 1'b1;
              next_lp_cnt = (lp_act ? lp_cnt : c_f0[7:0]) - 8'h01;
              next_ptr    = {ptr[15:8], c_f1[7:0]};
            end
          end
          eps_pkg::OP_WIDE_REP: begin
            // independent of the byte counter, so the kinds may nest
            if (zl_act && zl_cnt == 16'h0000) begin
              next_zl_act = 1'b0;
            end else if (!zl_act && c_f0 == 16'h0000) begin
              next_zl_act = 1'b0;
            end else begin
              next_zl_act = 1'b1;
              next_zl_cnt = (zl_act ? zl_cnt : c_f0) - eps_pkg::ONE16;
              next_ptr    = {ptr[15:8], c_f1[7:0]};
            end
          end
          eps_pkg::OP_MISMATCH_BR: begin
            if (bit_mismatch(c_f0[7:0], test_bits_i)) begin
              next_ptr = {ptr[15:8], c_f1[7:0]};
            end
          end
          default: begin
            // motion, bit and mode commands belong to other blocks
            next_exec_valid = 1'b1;
            next_exec_op    = c_op;
            next_exec_arg0  = c_f0;
            next_exec_arg1  = c_f1;
            next_state      = eps_pkg::ST_EXEC;
          end
        endcase
      end
    end

    // one character per two cycles and none while a command waits;
    // this keeps a second host command from overwriting the first
    next_host_ready = !next_hp_valid && !h_done && !h_take;
  end

  // sequencer registers
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state        <= eps_pkg::ST_DIRECT;
      in_run       <= 1'b0;
      ptr          <= eps_pkg::PTR_RST;
      hp_valid     <= 1'b0;
      hp_op        <= 8'h00;
      hp_f0        <= 16'h0000;
      hp_f1        <= 16'h0000;
      lp_cnt       <= 8'h00;
      lp_act       <= 1'b0;
      zl_cnt       <= 16'h0000;
      zl_act       <= 1'b0;
      host_ready_o <= 1'b0;
      mem_addr_o   <= eps_pkg::PTR_RST;
      mem_wdata_o  <= 8'h00;
      mem_we_o     <= 1'b0;
      mem_re_o     <= 1'b0;
      exec_valid_o <= 1'b0;
      exec_op_o    <= 8'h00;
      exec_arg0_o  <= 16'h0000;
      exec_arg1_o  <= 16'h0000;
      running_o    <= 1'b0;
      storing_o    <= 1'b0;
    end else begin
      state        <= next_state;
      in_run       <= next_in_run;
      ptr          <= next_ptr;
      hp_valid     <= next_hp_valid;
      hp_op        <= next_hp_op;
      hp_f0        <= next_hp_f0;
      hp_f1        <= next_hp_f1;
      lp_cnt       <= next_lp_cnt;
      lp_act       <= next_lp_act;
      zl_cnt       <= next_zl_cnt;
      zl_act       <= next_zl_act;
      host_ready_o <= next_host_ready;
      mem_addr_o   <= next_mem_addr;
      mem_wdata_o  <= next_mem_wdata;
      mem_we_o     <= next_mem_we;
      mem_re_o     <= next_mem_re;
      exec_valid_o <= next_exec_valid;
      exec_op_o    <= next_exec_op;
      exec_arg0_o  <= next_exec_arg0;
      exec_arg1_o  <= next_exec_arg1;
      running_o    <= next_in_run;
      storing_o    <= (next_state == eps_pkg::ST_ENTRY);
    end
  end

endmodule
